// >>> src/smd_defs.svh
/*
  Constants of the mode and datapath configuration block: register word
  addresses, reset values, ramp figures and sample masks.
  Assumes it is included by its bare name from the package and the core.
*/
`ifndef SMD_DEFS_SVH
`define SMD_DEFS_SVH
// avalon word addresses
`define SMD_A_CTRL 4'h0
`define SMD_A_STAT 4'h1
`define SMD_A_XBAR 4'h2
`define SMD_A_DCV 4'h3
`define SMD_A_GAIN0 4'h4
`define SMD_A_GAIN1 4'h5
`define SMD_A_GAIN2 4'h6
`define SMD_A_CFTW 4'h7
`define SMD_A_CMOD 4'h8
`define SMD_A_MFTW 4'h9
`define SMD_A_MMOD 4'hA
`define SMD_A_PTHR 4'hB
// link lane peek window occupies the top four words
`define SMD_A_PEEK 2'h3
// status field positions
`define SMD_ST_TRIP 2
// reset values
`define SMD_CTRL_RST 23'h002100
`define SMD_XBAR_RST 24'hFAC688
`define SMD_GAIN_RST 12'h800
`define SMD_PTHR_RST 16'h7FFF
// second link starts at this logical lane
`define SMD_LINK1_OFS 3'h4
// ramp gain: full scale and per-clock step
`define SMD_RAMP_FULL 9'h100
`define SMD_RAMP_STEP 9'h004
// 12-bit packing keeps the upper twelve bits
`define SMD_PW12_MASK 16'hFFF0
`define SMD_NCO_W 48
`endif

// >>> src/smd_pkg.sv
/*
  Types of the mode and datapath configuration block.
  Assumes smd_defs.svh is on the include path.
*/
`include "smd_defs.svh"
package smd_pkg;
  typedef enum logic [2:0] {CI1 = 3'b000, CI2 = 3'b001, CI3 = 3'b010,
                            CI4 = 3'b011, CI6 = 3'b100, CI8 = 3'b101} smd_ci_e;
  typedef enum logic [2:0] {MI1 = 3'b000, MI2 = 3'b001, MI4 = 3'b010,
                            MI6 = 3'b011, MI8 = 3'b100, MI12 = 3'b101} smd_mi_e;
  typedef enum logic [1:0] {SW_PASS = 2'b00, SW_INV = 2'b01,
                            SW_MOD = 2'b10, SW_HALF = 2'b11} smd_sw_e;
  typedef enum logic [1:0] {SR_OFF = 2'b00, SR_ONCE = 2'b01,
                            SR_CONT = 2'b10, SR_MON = 2'b11} smd_sref_e;
  typedef enum logic [1:0] {PA_OK = 2'b00, PA_DOWN = 2'b01,
                            PA_MUTED = 2'b10, PA_UP = 2'b11} smd_pa_e;
  typedef logic [7:0][15:0] smd_lanes_t;
  typedef logic [`SMD_NCO_W-1:0] smd_acc_t;
  typedef struct packed {
    logic      pa_en;
    smd_sref_e sref;
    logic      cal;
    logic      mn_mod_en;
    smd_sw_e   sw;
    logic      ch_mod_en;
    logic      nco_only;
    smd_mi_e   mi;
    smd_ci_e   ci;
    logic      enable;
    logic      page;
    logic      dual;
    logic [4:0] mode;
  } smd_ctrl_s;
  typedef struct packed {
    smd_ctrl_s        ctrl;
    logic [7:0][2:0]  xbar;
    logic [15:0]      dc;
    logic [2:0][11:0] gain;
    logic [31:0]      ch_ftw;
    logic [31:0]      ch_mod;
    logic [31:0]      mn_ftw;
    logic [31:0]      mn_mod;
    logic [15:0]      pa_thr;
    logic             wait_req;
    logic [31:0]      rdata;
    logic             sref_m;
    logic             sref_s;
    logic             sref_d;
    logic             aligned;
    logic             shot_done;
    logic             realign;
    logic [6:0]       rate_cnt;
    logic [6:0]       gap;
    logic             strobe;
    logic [1:0][2:0][`SMD_NCO_W-1:0] ch_acc;
    smd_acc_t         mn_acc;
    smd_pa_e          pa_st;
    logic [8:0]       ramp;
    logic             trip;
    logic             running;
    logic [1:0][15:0] dac;
  } smd_state_s;
endpackage

// >>> src/smd_core.sv
/*
  Mode and datapath configuration core: register file on an Avalon-MM slave,
  lane crossbar, mode table check, three channelizers per DAC, summing node,
  main NCO, PA protection with ramp gain, SYSREF alignment.
  Assumes lane_data arrives deserialized on clk, which is the device clock;
  sysref is an asynchronous pin.
*/
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`include "smd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - with page select set in dual link, link lane x reads logical lane x+4.
// - with page select clear, link lane x is logical lane x.
// - logical lane x is physical lane chosen by the programmable crossbar.
// - single or dual link operation follows the dual link configuration bit.
// - lanes per link follow the mode: one, two, three, four or eight; the mode table here stops at four.
// - sample data is clocked by the device clock, no separate data clock.
// - channel interpolation offers 1x, 2x, 3x, 4x, 6x and 8x.
// - main interpolation offers 1x, 2x, 4x, 6x, 8x and 12x.
// - channel gain and NCO act only when channel interpolation is not 1x.
// - channel NCO has an optional modulus mode.
// - NCO only mode feeds a programmed constant instead of lane data.
// - the three channel outputs are summed and fed to each main datapath; here only the first nch channels of the mode enter the sum.
// - PA protection drives a ramp gain that mutes the output on trip.
// - main NCO has four switch modes, modulus option and calibration tone.
// - latency stays fixed between link establishments.
// - SYSREF aligns timing with selectable handling modes.
// - mode 2: three lanes, three channels, 4x,6x with 6x,8x.
// - mode 5: one lane, one channel, 12-bit, 2x/6x or 3x/6x,8x.
// - mode 6: two lanes, two channels, 12-bit, 3x with 6x,8x.
// - mode 3: two lanes, one channel, 1x/8x or 2x,3x with 6x,8x.
// - mode 4: four lanes, two channels, 2x,3x/6x,8x or 4x/8x.
module smd_core
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // avalon-mm register slave
  input  wire logic [3:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // deserialized lanes and alignment pin
  input  wire smd_pkg::smd_lanes_t lane_data,
  input  wire logic              sysref,
  // datapath outputs
  output logic                   sample_take,
  output logic      [15:0]       dac0_data,
  output logic      [15:0]       dac1_data,
  output logic                   dp_running,
  output logic                   pa_tripped
);

  smd_pkg::smd_state_s r;
  smd_pkg::smd_state_s next_r;

  ////////////////////////////////////////////////////////////////////////////
  // mode table

  // supported interpolation pairs per mode
  function automatic logic combo_ok(input logic [4:0] m, input smd_pkg::smd_ci_e c,
                                    input smd_pkg::smd_mi_e i);
    logic m68;
    logic m8;
    m68 = (i == smd_pkg::MI6) || (i == smd_pkg::MI8);
    m8 = (i == smd_pkg::MI8);
    case (m)
      5'h00: combo_ok = (c == smd_pkg::CI2 && m8) || ((c == smd_pkg::CI4 || c == smd_pkg::CI6) && m68);
      5'h01, 5'h02: combo_ok = (c == smd_pkg::CI4 || c == smd_pkg::CI6) && m68;
      5'h03: combo_ok = (c == smd_pkg::CI1 && m8) || ((c == smd_pkg::CI2 || c == smd_pkg::CI3) && m68);
      5'h04: combo_ok = ((c == smd_pkg::CI2 || c == smd_pkg::CI3) && m68) || (c == smd_pkg::CI4 && m8);
      5'h05: combo_ok = (c == smd_pkg::CI2 && i == smd_pkg::MI6) || (c == smd_pkg::CI3 && m68);
      5'h06: combo_ok = (c == smd_pkg::CI3) && m68;
      default: combo_ok = 1'b0;
    endcase
  endfunction

  // lanes per link and channels per DAC, packed {lanes, channels}
  function automatic logic [5:0] mode_shape(input logic [4:0] m);
    case (m)
      5'h00, 5'h05: mode_shape = {4'h1, 2'h1};
      5'h01, 5'h06: mode_shape = {4'h2, 2'h2};
      5'h02: mode_shape = {4'h3, 2'h3};
      5'h03: mode_shape = {4'h2, 2'h1};
      5'h04: mode_shape = {4'h4, 2'h2};
      default: mode_shape = {4'h0, 2'h0};
    endcase
  endfunction

  function automatic logic [3:0] ci_fac(input smd_pkg::smd_ci_e c);
    case (c)
      smd_pkg::CI2: ci_fac = 4'h2;
      smd_pkg::CI3: ci_fac = 4'h3;
      smd_pkg::CI4: ci_fac = 4'h4;
      smd_pkg::CI6: ci_fac = 4'h6;
      smd_pkg::CI8: ci_fac = 4'h8;
      default: ci_fac = 4'h1;
    endcase
  endfunction

  function automatic logic [3:0] mi_fac(input smd_pkg::smd_mi_e i);
    case (i)
      smd_pkg::MI2: mi_fac = 4'h2;
      smd_pkg::MI4: mi_fac = 4'h4;
      smd_pkg::MI6: mi_fac = 4'h6;
      smd_pkg::MI8: mi_fac = 4'h8;
      smd_pkg::MI12: mi_fac = 4'hC;
      default: mi_fac = 4'h1;
    endcase
  endfunction

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07FFF)
      sat16 = 16'h7FFF;
    else if (v < -18'sh08000)
      sat16 = 16'h8000;
    else
      sat16 = v[15:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (o & ~m) | (w & m);
  endfunction

  // nco step with optional wrap at a modulus
  function automatic smd_pkg::smd_acc_t nco_step(input smd_pkg::smd_acc_t a,
                                                 input logic [31:0] f, input logic [31:0] md,
                                                 input logic en);
    smd_pkg::smd_acc_t s;
    s = a + {16'h0000, f};
    if (en && md != 32'h0 && s >= {16'h0000, md})
      s = s - {16'h0000, md};
    nco_step = s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational helpers shared with the checks

  logic              valid;
  logic [3:0]        lpl;
  logic [1:0]        nch;
  logic [6:0]        total;
  logic [7:0][15:0]  logl;
  logic              req;
  logic              edge_s;

  // crossbar and mode decode
  always_comb
  begin
    valid = combo_ok(r.ctrl.mode, r.ctrl.ci, r.ctrl.mi);
    {lpl, nch} = mode_shape(r.ctrl.mode);
    // widen before the product so 6x times 8x does not wrap in four bits
    total = 7'(ci_fac(r.ctrl.ci)) * 7'(mi_fac(r.ctrl.mi));
    for (int i = 0; i < 8; i++)
      logl[i] = lane_data[r.xbar[i]];
    req = read | write;
    edge_s = r.sref_s & ~r.sref_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [2:0]         pk;
    logic [2:0]         li;
    logic [15:0]        x;
    logic signed [28:0] p;
    logic signed [17:0] sum [2];
    logic [15:0]        m;
    logic signed [25:0] q;
    logic               over;
    logic               clr;
    logic               go;
    next_r = r;
    pk = 3'h0;
    li = 3'h0;
    x = 16'h0;
    p = 29'sh0;
    m = 16'h0;
    q = 26'sh0;
    over = 1'b0;
    sum[0] = 18'sh0;
    sum[1] = 18'sh0;
    clr = 1'b0;
    go = 1'b0;
    // one wait state: data latched on first cycle, taken on the second
    next_r.wait_req = !(req && r.wait_req);
    if (read && r.wait_req)
    begin
      pk = (r.ctrl.page && r.ctrl.dual) ? 3'({1'b0, address[1:0]} + `SMD_LINK1_OFS)
                                        : {1'b0, address[1:0]};
      case (address)
        `SMD_A_CTRL: next_r.rdata = 32'(r.ctrl);
        `SMD_A_STAT: next_r.rdata = {22'h0, nch, lpl, r.aligned, r.trip, r.running, valid};
        `SMD_A_XBAR: next_r.rdata = 32'(r.xbar);
        `SMD_A_DCV: next_r.rdata = {16'h0, r.dc};
        `SMD_A_GAIN0: next_r.rdata = {20'h0, r.gain[0]};
        `SMD_A_GAIN1: next_r.rdata = {20'h0, r.gain[1]};
        `SMD_A_GAIN2: next_r.rdata = {20'h0, r.gain[2]};
        `SMD_A_CFTW: next_r.rdata = r.ch_ftw;
        `SMD_A_CMOD: next_r.rdata = r.ch_mod;
        `SMD_A_MFTW: next_r.rdata = r.mn_ftw;
        `SMD_A_MMOD: next_r.rdata = r.mn_mod;
        `SMD_A_PTHR: next_r.rdata = {16'h0, r.pa_thr};
        default: next_r.rdata = (address[3:2] == `SMD_A_PEEK) ? {16'h0, logl[pk]} : 32'h0;
      endcase
    end
    // writes take effect at the edge where waitrequest is low
    if (write && !r.wait_req)
    begin
      case (address)
        `SMD_A_CTRL: next_r.ctrl = smd_pkg::smd_ctrl_s'(23'(merge(32'(r.ctrl), writedata, byteenable)));
        `SMD_A_STAT: clr = byteenable[0] && writedata[`SMD_ST_TRIP];
        `SMD_A_XBAR: next_r.xbar = 24'(merge(32'(r.xbar), writedata, byteenable));
        `SMD_A_DCV: next_r.dc = 16'(merge({16'h0, r.dc}, writedata, byteenable));
        `SMD_A_GAIN0: next_r.gain[0] = 12'(merge({20'h0, r.gain[0]}, writedata, byteenable));
        `SMD_A_GAIN1: next_r.gain[1] = 12'(merge({20'h0, r.gain[1]}, writedata, byteenable));
        `SMD_A_GAIN2: next_r.gain[2] = 12'(merge({20'h0, r.gain[2]}, writedata, byteenable));
        `SMD_A_CFTW: next_r.ch_ftw = merge(r.ch_ftw, writedata, byteenable);
        `SMD_A_CMOD: next_r.ch_mod = merge(r.ch_mod, writedata, byteenable);
        `SMD_A_MFTW: next_r.mn_ftw = merge(r.mn_ftw, writedata, byteenable);
        `SMD_A_MMOD: next_r.mn_mod = merge(r.mn_mod, writedata, byteenable);
        `SMD_A_PTHR: next_r.pa_thr = 16'(merge({16'h0, r.pa_thr}, writedata, byteenable));
        default: ;
      endcase
    end

    // sysref: two-flop synchroniser, then edge on the settled copy
    next_r.sref_m = sysref;
    next_r.sref_s = r.sref_m;
    next_r.sref_d = r.sref_s;
    next_r.realign = 1'b0;
    case (r.ctrl.sref)
      smd_pkg::SR_OFF: next_r.aligned = 1'b1;
      smd_pkg::SR_ONCE:
      begin
        if (edge_s && !r.shot_done)
        begin
          next_r.realign = 1'b1;
          next_r.shot_done = 1'b1;
          next_r.aligned = 1'b1;
        end
      end
      smd_pkg::SR_CONT:
      begin
        if (edge_s)
        begin
          next_r.realign = 1'b1;
          next_r.aligned = 1'b1;
        end
      end
      smd_pkg::SR_MON:
      begin
        if (edge_s)
          next_r.aligned = 1'b1;
      end
      default: ;
    endcase

    // run only on a supported, enabled, aligned configuration
    go = r.ctrl.enable && valid && r.aligned;
    next_r.running = go;

    // sample cadence from the device clock; realign restarts it at a fixed phase
    next_r.strobe = 1'b0;
    if (r.realign || !r.running)
      next_r.rate_cnt = 7'h0;
    else if (r.rate_cnt == 7'h0)
    begin
      next_r.strobe = 1'b1;
      next_r.rate_cnt = total - 7'h1;
    end
    else
      next_r.rate_cnt = r.rate_cnt - 7'h1;
    next_r.gap = (r.strobe || r.realign || !r.running) ? 7'h0 : r.gap + 7'h1;

    // channelizers and summing node for each DAC
    for (int d = 0; d < 2; d++)
    begin
      for (int c = 0; c < 3; c++)
      begin
        li = 3'(((r.ctrl.dual && d == 1) ? 4 : 0) + c * ((lpl > 4'(nch)) ? 2 : 1));
        x = r.ctrl.nco_only ? r.dc : logl[li];
        if (r.ctrl.mode == 5'h05 || r.ctrl.mode == 5'h06)
          x = x & `SMD_PW12_MASK;
        if (r.ctrl.ci != smd_pkg::CI1)
        begin
          p = $signed(x) * $signed({1'b0, r.gain[c]});
          x = p[26:11];
          if (r.ch_acc[d][c][`SMD_NCO_W-1])
            x = 16'(-$signed(x));
          if (r.strobe)
            next_r.ch_acc[d][c] = nco_step(r.ch_acc[d][c], r.ch_ftw, r.ch_mod,
                                           r.ctrl.ch_mod_en);
        end
        if (c < 32'(nch))
          sum[d] = sum[d] + 18'($signed(x));
      end
      over = over | (r.ctrl.pa_en && ((sum[d] < 0 ? -sum[d] : sum[d]) > $signed({2'b00, r.pa_thr})));
      // main datapath: switch mode, tone, ramp gain
      m = sat16(sum[d]);
      case (r.ctrl.sw)
        smd_pkg::SW_PASS: m = m;
        smd_pkg::SW_INV: m = 16'(-$signed(m));
        smd_pkg::SW_MOD: m = r.mn_acc[`SMD_NCO_W-1] ? 16'(-$signed(m)) : m;
        smd_pkg::SW_HALF: m = r.mn_acc[`SMD_NCO_W-2] ? 16'(-$signed(m)) : m;
        default: m = m;
      endcase
      if (r.ctrl.cal)
        m = r.mn_acc[`SMD_NCO_W-1] ? 16'h7FFF : 16'h8001;
      q = $signed(m) * $signed({1'b0, r.ramp});
      if (!r.running)
        next_r.dac[d] = 16'h0;
      else if (r.strobe)
        next_r.dac[d] = q[23:8];
    end
    if (r.strobe)
      next_r.mn_acc = nco_step(r.mn_acc, r.mn_ftw, r.mn_mod, r.ctrl.mn_mod_en);
    if (r.realign)
    begin
      next_r.ch_acc = '0;
      next_r.mn_acc = '0;
    end

    // pa protection: trip ramps to mute, software clear ramps back up
    over = over && r.strobe;
    next_r.trip = (r.trip && !clr) || over;
    case (r.pa_st)
      smd_pkg::PA_OK:
        if (over)
          next_r.pa_st = smd_pkg::PA_DOWN;
      smd_pkg::PA_DOWN:
      begin
        if (r.ramp <= `SMD_RAMP_STEP)
        begin
          next_r.ramp = 9'h0;
          next_r.pa_st = smd_pkg::PA_MUTED;
        end
        else
          next_r.ramp = r.ramp - `SMD_RAMP_STEP;
      end
      smd_pkg::PA_MUTED:
        if (!r.trip)
          next_r.pa_st = smd_pkg::PA_UP;
      smd_pkg::PA_UP:
      begin
        if (over)
          next_r.pa_st = smd_pkg::PA_DOWN;
        else if (r.ramp >= `SMD_RAMP_FULL - `SMD_RAMP_STEP)
        begin
          next_r.ramp = `SMD_RAMP_FULL;
          next_r.pa_st = smd_pkg::PA_OK;
        end
        else
          next_r.ramp = r.ramp + `SMD_RAMP_STEP;
      end
      default: next_r.pa_st = smd_pkg::PA_OK;
    endcase

    // synchronous reset values
    if (!rst_b)
    begin
      next_r = '0;
      next_r.ctrl = smd_pkg::smd_ctrl_s'(`SMD_CTRL_RST);
      next_r.xbar = `SMD_XBAR_RST;
      next_r.gain = {3{`SMD_GAIN_RST}};
      next_r.pa_thr = `SMD_PTHR_RST;
      next_r.wait_req = 1'b1;
      next_r.ramp = `SMD_RAMP_FULL;
    end
  end

  // single state register
  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  assign readdata = r.rdata;
  assign waitrequest = r.wait_req;
  assign sample_take = r.strobe;
  assign dac0_data = r.dac[0];
  assign dac1_data = r.dac[1];
  assign dp_running = r.running;
  assign pa_tripped = r.trip;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_peek_req;
    read && waitrequest && address[3:2] == `SMD_A_PEEK;
  endsequence
  sequence s_sref_edge;
    r.ctrl.sref == smd_pkg::SR_CONT && edge_s;
  endsequence

  a_page_high_map: assert property (s_peek_req ##0 r.ctrl.page && r.ctrl.dual |=>
    readdata[15:0] == $past(logl[{1'b1, address[1:0]}]))
    else $error("page one peek not offset by four");
  a_page_low_map: assert property (s_peek_req ##0 !r.ctrl.page |=>
    readdata[15:0] == $past(logl[address[1:0]]))
    else $error("page zero peek not identity");
  a_invalid_idle: assert property (!valid |=> !dp_running ##1 dac0_data == 16'h0)
    else $error("datapath runs on unsupported combination");
  a_strobe_gap: assert property (sample_take |-> r.gap < total)
    else $error("sample cadence longer than interpolation product");
  a_sref_align: assert property (s_sref_edge |=> r.realign ##1 r.rate_cnt == 7'h0)
    else $error("sysref edge did not realign");
  a_pa_mute: assert property (r.pa_st == smd_pkg::PA_MUTED && sample_take |=> dac0_data == 16'h0)
    else $error("output not muted after trip");
  a_trip_hold: assert property (pa_tripped && !(write && !waitrequest) |=> pa_tripped)
    else $error("trip flag lost without clear");
  a_mode3_shape: assert property (r.ctrl.mode == 5'h03 |-> lpl == 4'h2 && nch == 2'h1)
    else $error("mode 3 shape wrong");
  a_mode4_combo: assert property (r.ctrl.mode == 5'h04 && r.ctrl.ci == smd_pkg::CI4 |->
    valid == (r.ctrl.mi == smd_pkg::MI8))
    else $error("mode 4 channel 4x combination wrong");
  a_mode6_combo: assert property (r.ctrl.mode == 5'h06 && r.ctrl.ci == smd_pkg::CI2 |-> !valid)
    else $error("mode 6 accepts 2x");
  a_bus_wait: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not one cycle");

endmodule // smd_core
`default_nettype wire

// >>> bench/smd_lane_src.sv
/*
  Lane source standing in for the link transmitter in logic.
  Assumes the receiver takes one frame per sample_take pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module smd_lane_src
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // consumption pulse and lanes
  input  wire logic               sample_take,
  output var smd_pkg::smd_lanes_t lane_data
);
  logic [7:0] cnt;
  // next frame only once one was taken; no data clock of our own
  always_ff @(posedge clk)
    cnt <= !rst_b ? 8'h00 : cnt + {7'h00, sample_take};
  // lane number in the top nibble makes any remap visible
  always_comb
    for (int i = 0; i < 8; i++)
      lane_data[i] = {i[3:0], 4'h5, cnt};
endmodule // smd_lane_src
`default_nettype wire

// >>> bench/serdes_mode_datapath_config_bench.sv
/*
  Bench of the mode and datapath core: reset values, mode table, lane paging,
  sample pacing and PA mute, configured through Avalon-MM calls and watched at the core's ports.
  Assumes the package, the core and smd_lane_src are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module serdes_mode_datapath_config_bench;
  logic                clk, rst_b, read, write, sysref, waitrequest;
  logic                sample_take, dp_running, pa_tripped;
  logic [3:0]          address, byteenable;
  logic [31:0]         writedata, readdata, q, x;
  logic [15:0]         dac0_data, dac1_data, v;
  smd_pkg::smd_lanes_t lane_data;
  int                  bad_count = 0, n_compared = 0, j, k, n;
  // mode, ci code, mi code, valid, lanes per link, channels per DAC
  logic [31:0] tbl [14] = '{32'h0141_1100, 32'h1331_2200, 32'h2441_3300, 32'h3041_2100,
    32'h4341_4200, 32'h5131_1100, 32'h6241_2200, 32'h4330_0000, 32'h5140_0000,
    32'h0040_0000, 32'h7140_0000, 32'h0550_0000, 32'h3110_0000, 32'h0120_0000};
  smd_core u_smd_core
  (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .lane_data(lane_data), .sysref(sysref),
    .sample_take(sample_take), .dac0_data(dac0_data), .dac1_data(dac1_data),
    .dp_running(dp_running), .pa_tripped(pa_tripped)
  );
  smd_lane_src u_smd_lane_src
  (
    .clk(clk), .rst_b(rst_b), .sample_take(sample_take), .lane_data(lane_data)
  );
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // request held until waitrequest is sampled low; a spare edge keeps drives apart
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, q & m);
  endtask
  // watchdog far beyond the expected run of about five hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hF;
    sysref = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(4'h0, 32'h0000_2100, 32'hFFFF_FFFF, "ctrl");
    rd(4'h2, 32'h00FA_C688, 32'hFFFF_FFFF, "xbar");
    rd(4'h4, 32'h0000_0800, 32'hFFFF_FFFF, "gain0");
    rd(4'hB, 32'h0000_7FFF, 32'hFFFF_FFFF, "pa_thr");
    // every supported mode plus near misses; the lane field is masked when invalid
    for (k = 0; k < 14; k++)
    begin
      x = tbl[k];
      wr(4'h0, {18'h0, x[22:20], x[26:24], 4'h0, x[31:28]});
      rd(4'h1, x[16] ? {22'h0, x[9:8], x[15:12], 4'h1} : 32'h0, x[16] ? 32'h3F1 : 32'h1,
         "status");
    end
    // reversed crossbar, then the four page and link settings
    x = 32'h0;
    for (k = 0; k < 8; k++)
      x[3*k +: 3] = 3'(7 - k);
    wr(4'h2, x);
    for (j = 0; j < 4; j++)
    begin
      wr(4'h0, 32'h0000_2100 | (32'(j) << 5));
      for (k = 0; k < 4; k++)
        rd(4'hC + 4'(k), {16'h0, 4'(7 - k - 4 * (j / 3)), 12'h500}, 32'h0000_FF00,
           "peek");
    end
    wr(4'h2, 32'h00FA_C688);
    // mode 3 with 1x channel: samples pass with no gain or rotation
    wr(4'h0, 32'h0000_2083);
    for (k = 0; k < 3; k++)
    begin
      do @(posedge clk); while (sample_take !== 1'b1);
      v = lane_data[0];
      @(posedge clk);
      chk("dac0", 32'(v), 32'(dac0_data));
      chk("dac1", 32'(v), 32'(dac1_data));
    end
    chk("running", 32'h1, 32'(dp_running));
    n = 0;
    repeat (64)
    begin
      @(posedge clk);
      if (sample_take === 1'b1) n++;
    end
    chk("takes", 32'd8, 32'(n));
    // sysref edge in continuous mode realigns the cadence; the core's check watches it
    wr(4'h0, 32'h0020_2083);
    sysref <= 1'b1;
    repeat (8) @(posedge clk);
    sysref <= 1'b0;
    rd(4'h1, 32'h0000_000B, 32'h0000_000B, "status");
    // unsupported mode 1 at 1x stays off; one take may still be in flight
    wr(4'h0, 32'h0000_2081);
    repeat (2) @(posedge clk);
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      if (sample_take === 1'b1) n++;
    end
    chk("takes", 32'd0, 32'(n));
    chk("running", 32'h0, 32'(dp_running));
    chk("dac0", 32'h0, 32'(dac0_data));
    // low threshold trips protection; the ramp needs 64 clocks to mute
    wr(4'hB, 32'h0000_0010);
    wr(4'h0, 32'h0040_2083);
    repeat (120) @(posedge clk);
    chk("trip", 32'h1, 32'(pa_tripped));
    chk("dac0", 32'h0, 32'(dac0_data));
    rd(4'h1, 32'h4, 32'h4, "status");
    end_of_test();
  end
endmodule // serdes_mode_datapath_config_bench
`default_nettype wire
